// [verilog/xorex_exec.sv]
`timescale 1ns/10ps
// Operation
// - An immediate pattern word XORs the accumulator with its low 8-bit literal into it.
// - The immediate form is one word and completes in one instruction cycle.
// - A register pattern word XORs the accumulator with the file register at index 0..31.
// - Destination bit 0 writes the accumulator, bit 1 writes the selected file register.
// - Both forms update the zero flag only and leave other status flags alone.
// - The register form is one word and one cycle for either destination.
module xorex_exec (
    input  wire logic                            clk,
    input  wire logic                            srst,
    input  wire logic                            insn_valid,
    input  wire logic [xorex_pkg::INSN_W-1:0]    insn,
    input  wire logic [xorex_pkg::DATA_W-1:0]    file_rdata,
    output logic      [xorex_pkg::INDEX_W-1:0]   file_addr,
    output logic      [xorex_pkg::DATA_W-1:0]    file_wdata,
    output logic                                 file_we,
    output logic      [xorex_pkg::DATA_W-1:0]    acc,
    output logic                                 zero_flag,
    output logic                                 zero_we,
    output logic                                 done
);
    import xorex_pkg::*;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    xorex_dec_if dec_bus ();

    xorex_decode u_dec (
        .insn (insn),
        .dec  (dec_bus)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // The checks match the opcode fields here rather than through the decoder, so
    // that a broken decoder shows up as a failed check instead of hiding.
    logic                    imm_taken;
    logic                    reg_taken;
    logic                    xor_taken;

    function automatic logic word_is_imm(input logic [INSN_W-1:0] word);
        return word[IMM_OP_HI:IMM_OP_LO] == IMM_OPCODE;
    endfunction

    function automatic logic word_is_reg(input logic [INSN_W-1:0] word);
        return word[REG_OP_HI:REG_OP_LO] == REG_OPCODE;
    endfunction

    // One zero test for both forms, so the flag rule lives in one place.
    function automatic logic is_zero(input logic [DATA_W-1:0] value);
        return value == DATA_ZERO;
    endfunction

    assign imm_taken = insn_valid && word_is_imm(insn);
    assign reg_taken = insn_valid && word_is_reg(insn);
    assign xor_taken = imm_taken || reg_taken;

    // ------------------------------------------------------------------
    // Execute
    // ------------------------------------------------------------------
    // The core drives file_rdata combinationally from insn's index in the same
    // cycle, so each instruction retires on the edge it is presented; a
    // registered file port would cost a second cycle and break single-cycle use.
    xorex_op_type            op;
    logic [DATA_W-1:0]       result;
    logic [DATA_W-1:0]       next_acc;
    logic                    next_zero_flag;
    logic                    next_zero_we;
    logic [DATA_W-1:0]       next_file_wdata;
    logic [INDEX_W-1:0]      next_file_addr;
    logic                    next_file_we;
    logic                    next_done;

    always_comb begin
        op = XOREX_IDLE;
        if (insn_valid && dec_bus.is_imm) begin
            op = XOREX_IMM;
        end else if (insn_valid && dec_bus.is_reg) begin
            op = XOREX_REG;
        end
        next_acc        = acc;
        next_zero_flag  = zero_flag;
        next_zero_we    = 1'b0;
        next_file_wdata = file_wdata;
        next_file_addr  = file_addr;
        next_file_we    = 1'b0;
        next_done       = 1'b0;
        result          = DATA_ZERO;
        case (op)
            XOREX_IMM: begin
                result         = acc ^ dec_bus.literal;
                next_acc       = result;
                next_zero_flag = is_zero(result);
                next_zero_we   = 1'b1;
                next_done      = 1'b1;
            end
            XOREX_REG: begin
                result         = acc ^ file_rdata;
                next_zero_flag = is_zero(result);
                next_zero_we   = 1'b1;
                next_done      = 1'b1;
                if (dec_bus.dest_file) begin
                    next_file_wdata = result;
                    next_file_addr  = dec_bus.index;
                    next_file_we    = 1'b1;
                end else begin
                    next_acc = result;
                end
            end
            default: begin
                next_done = 1'b0;
            end
        endcase
    end

    // Every output, the file port included, is cleared by reset so that no
    // stale write data can sit on the port while the core restarts.
    always_ff @(posedge clk) begin
        if (srst) begin
            acc        <= ACC_RESET;
            zero_flag  <= 1'b0;
            zero_we    <= 1'b0;
            file_wdata <= DATA_ZERO;
            file_addr  <= INDEX_ZERO;
            file_we    <= 1'b0;
            done       <= 1'b0;
        end else begin
            acc        <= next_acc;
            zero_flag  <= next_zero_flag;
            zero_we    <= next_zero_we;
            file_wdata <= next_file_wdata;
            file_addr  <= next_file_addr;
            file_we    <= next_file_we;
            done       <= next_done;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // The antecedents use the local word match, not the decoder, and every check but
    // file_write_done_a, strobe_pair_a and zero_clear_a looks one edge ahead (reg_one_cycle_a two) because each form retires on the next edge.
    // A reset in mid-run is covered by the disable clause, which drops any
    // attempt whose look ahead lands on a reset edge.
    imm_result_a: assert property (@(posedge clk) disable iff (srst)
        imm_taken |=> acc == ($past(acc) ^ $past(insn[LIT_HI:0])))
        else $error("immediate xor result wrong");

    imm_no_file_a: assert property (@(posedge clk) disable iff (srst)
        imm_taken |=> !file_we)
        else $error("immediate xor wrote a file register");

    imm_one_cycle_a: assert property (@(posedge clk) disable iff (srst)
        imm_taken |=> done && zero_we)
        else $error("immediate xor not done in one cycle");

    done_single_a: assert property (@(posedge clk) disable iff (srst)
        done |=> !done || $past(xor_taken))
        else $error("done stood longer than one cycle");

    idle_no_done_a: assert property (@(posedge clk) disable iff (srst)
        !xor_taken |=> !done)
        else $error("done raised without an xor word");

    reg_file_dest_a: assert property (@(posedge clk) disable iff (srst)
        reg_taken && insn[DEST_BIT] |=>
            file_we && file_addr == $past(insn[INDEX_HI:0])
            && file_wdata == ($past(acc) ^ $past(file_rdata)) && acc == $past(acc))
        else $error("register xor to file wrong");

    reg_acc_dest_a: assert property (@(posedge clk) disable iff (srst)
        reg_taken && !insn[DEST_BIT] |=>
            !file_we && acc == ($past(acc) ^ $past(file_rdata)))
        else $error("register xor to accumulator wrong");

    file_port_hold_a: assert property (@(posedge clk) disable iff (srst)
        !(reg_taken && insn[DEST_BIT]) |=>
            file_addr == $past(file_addr) && file_wdata == $past(file_wdata))
        else $error("file port moved without a file write");

    file_write_done_a: assert property (@(posedge clk) disable iff (srst)
        file_we |-> done && zero_we)
        else $error("file write without a retired xor");

    file_we_single_a: assert property (@(posedge clk) disable iff (srst)
        file_we |=> !file_we || $past(reg_taken))
        else $error("file write stood longer than one cycle");

    flag_hold_a: assert property (@(posedge clk) disable iff (srst)
        !xor_taken |=>
            !zero_we && !file_we && zero_flag == $past(zero_flag) && acc == $past(acc))
        else $error("state changed without xor");

    strobe_pair_a: assert property (@(posedge clk) disable iff (srst)
        zero_we == done)
        else $error("zero write strobe and done disagree");

    reg_one_cycle_a: assert property (@(posedge clk) disable iff (srst)
        reg_taken |=> done ##1 (!done || $past(xor_taken)))
        else $error("register xor not single cycle");

    reg_done_pulse_a: assert property (@(posedge clk) disable iff (srst)
        reg_taken |=> done && zero_we)
        else $error("register xor not done in one cycle");

    zero_set_a: assert property (@(posedge clk) disable iff (srst)
        imm_taken && (acc ^ insn[LIT_HI:0]) == DATA_ZERO |=> zero_flag)
        else $error("zero flag not set");

    imm_zero_clear_a: assert property (@(posedge clk) disable iff (srst)
        imm_taken && (acc ^ insn[LIT_HI:0]) != DATA_ZERO |=> !zero_flag)
        else $error("zero flag not cleared");

    reg_zero_set_a: assert property (@(posedge clk) disable iff (srst)
        reg_taken && (acc ^ file_rdata) == DATA_ZERO |=> zero_flag)
        else $error("zero flag not set by register xor");

    reg_flag_file_a: assert property (@(posedge clk) disable iff (srst)
        reg_taken && insn[DEST_BIT] |=> zero_flag == (file_wdata == DATA_ZERO))
        else $error("zero flag disagrees with file write data");

    zero_clear_a: assert property (@(posedge clk) disable iff (srst)
        zero_we |-> zero_flag == ((file_we ? file_wdata : acc) == DATA_ZERO))
        else $error("zero flag disagrees with result");
endmodule

// [verilog/xorex_pkg.sv]
package xorex_pkg;
    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int DATA_W  = 8;
    localparam int INSN_W  = 12;
    localparam int INDEX_W = 5;

    // ------------------------------------------------------------------
    // Instruction fields and patterns
    // ------------------------------------------------------------------
    localparam int IMM_OP_HI  = 11;
    localparam int IMM_OP_LO  = 8;
    localparam logic [3:0] IMM_OPCODE = 4'hf;
    localparam int REG_OP_HI  = 11;
    localparam int REG_OP_LO  = 6;
    localparam logic [5:0] REG_OPCODE = 6'h06;
    localparam int DEST_BIT   = 5;
    localparam int LIT_HI     = 7;
    localparam int INDEX_HI   = 4;

    // ------------------------------------------------------------------
    // Reset values and state
    // ------------------------------------------------------------------
    localparam logic [7:0] ACC_RESET  = 8'h00;
    localparam logic [7:0] DATA_ZERO  = 8'h00;
    localparam logic [4:0] INDEX_ZERO = 5'h00;

    typedef enum logic [2:0] {
        XOREX_IDLE = 3'h1,
        XOREX_IMM  = 3'h2,
        XOREX_REG  = 3'h4
    } xorex_op_type;
endpackage

// [verilog/xorex_dec_if.sv]
`timescale 1ns/10ps
interface xorex_dec_if;
    import xorex_pkg::*;
    logic                 is_imm;
    logic                 is_reg;
    logic                 dest_file;
    logic [DATA_W-1:0]    literal;
    logic [INDEX_W-1:0]   index;
    modport dec (output is_imm, is_reg, dest_file, literal, index);
    modport use_side (input is_imm, is_reg, dest_file, literal, index);
endinterface

// [verilog/xorex_decode.sv]
`timescale 1ns/10ps
module xorex_decode (
    input  wire logic [xorex_pkg::INSN_W-1:0] insn,
    xorex_dec_if.dec                          dec
);
    import xorex_pkg::*;

    always_comb begin
        dec.is_imm    = (insn[IMM_OP_HI:IMM_OP_LO] == IMM_OPCODE);
        dec.is_reg    = (insn[REG_OP_HI:REG_OP_LO] == REG_OPCODE);
        dec.dest_file = insn[DEST_BIT];
        dec.literal   = insn[LIT_HI:0];
        dec.index     = insn[INDEX_HI:0];
    end
endmodule

// [testbench/xor_instruction_exec_test.sv]
`timescale 1ns/10ps
module xor_instruction_exec_test;
    import xorex_pkg::*;
    logic                clk        = 1'b0;
    logic                srst       = 1'b1;
    logic                insn_valid = 1'b0;
    logic [INSN_W-1:0]   insn       = 12'h000;
    logic [DATA_W-1:0]   file_rdata = 8'h00;
    logic [INDEX_W-1:0]  file_addr;
    logic [DATA_W-1:0]   file_wdata;
    logic                file_we;
    logic [DATA_W-1:0]   acc;
    logic                zero_flag;
    logic                zero_we;
    logic                done;
    int                  fail_count  = 0;
    int                  comparisons = 0;
    logic [DATA_W-1:0]   model_acc   = 8'h00;

    always #2 clk = ~clk;

    xorex_exec xorex_exec_inst (
        .clk        (clk),
        .srst       (srst),
        .insn_valid (insn_valid),
        .insn       (insn),
        .file_rdata (file_rdata),
        .file_addr  (file_addr),
        .file_wdata (file_wdata),
        .file_we    (file_we),
        .acc        (acc),
        .zero_flag  (zero_flag),
        .zero_we    (zero_we),
        .done       (done)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Inputs change at the falling edge, so results are judged a full cycle later.
    task automatic issue(input logic v, input logic [11:0] w, input logic [7:0] rd);
        insn_valid = v;
        insn = w;
        file_rdata = rd;
        @(negedge clk);
    endtask

    task automatic pulses(input logic p);
        chk({7'h00, done}, {7'h00, p});
        chk({7'h00, zero_we}, {7'h00, p});
    endtask

    task automatic do_imm(input logic [7:0] lit);
        logic [7:0] res;
        res = model_acc ^ lit;
        issue(1'b1, {4'hf, lit}, ~lit);
        chk(acc, res);
        chk({7'h00, zero_flag}, {7'h00, res == 8'h00});
        pulses(1'b1);
        chk({7'h00, file_we}, 8'h00);
        model_acc = res;
    endtask

    task automatic do_reg(input logic d, input logic [4:0] idx, input logic [7:0] rd);
        logic [7:0] res;
        res = model_acc ^ rd;
        issue(1'b1, {6'h06, d, idx}, rd);
        chk({7'h00, zero_flag}, {7'h00, res == 8'h00});
        pulses(1'b1);
        chk({7'h00, file_we}, {7'h00, d});
        if (d) begin
            chk({3'h0, file_addr}, {3'h0, idx});
            chk(file_wdata, res);
            chk(acc, model_acc);
        end else begin
            chk(acc, res);
            model_acc = res;
        end
    endtask

    task automatic complete_run;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset;
        chk(acc, ACC_RESET);
        chk({zero_flag, zero_we, done, file_we, 4'h0}, 8'h00);
        chk({3'h0, file_addr}, 8'h00);
        chk(file_wdata, 8'h00);
        $display("test_reset finished");
    endtask

    // Back to back words, so the accumulator must chain without a bubble.
    task automatic test_immediate;
        do_imm(8'hb5);
        do_imm(8'haf);
        do_imm(8'h1a);
        do_imm(8'hff);
        issue(1'b0, 12'h000, 8'h00);
        $display("test_immediate finished");
    endtask

    task automatic test_register;
        do_reg(1'b0, 5'h03, 8'haf);
        do_reg(1'b1, 5'h1f, model_acc);
        do_reg(1'b1, 5'h00, 8'h3c);
        do_reg(1'b0, 5'h1f, 8'h81);
        issue(1'b0, 12'h000, 8'h00);
        $display("test_register finished");
    endtask

    // Words of other instructions, or no valid, must raise no done, zero_we or file_we and leave acc and zero_flag alone.
    task automatic test_refused;
        logic [11:0] words [4] = '{12'hfaf, 12'h3a3, 12'h1c3, 12'h000};
        foreach (words[i]) begin
            issue(i != 0, words[i], 8'h5a);
            pulses(1'b0);
            chk({7'h00, file_we}, 8'h00);
            chk(acc, model_acc);
            chk({7'h00, zero_flag}, {7'h00, model_acc == 8'h00});
        end
        issue(1'b0, 12'h000, 8'h00);
        $display("test_refused finished");
    endtask

    // A reset in mid-run must win over a pending word and clear acc, zero_flag, zero_we, done and file_we.
    task automatic test_midreset;
        do_imm(8'h3c);
        srst = 1'b1;
        issue(1'b1, {4'hf, 8'h55}, 8'h00);
        issue(1'b1, {4'hf, 8'h55}, 8'h00);
        srst = 1'b0;
        model_acc = ACC_RESET;
        chk(acc, ACC_RESET);
        chk({zero_flag, zero_we, done, file_we, 4'h0}, 8'h00);
        do_imm(8'h55);
        issue(1'b0, 12'h000, 8'h00);
        $display("test_midreset finished");
    endtask

    initial begin
        repeat (12) @(negedge clk);
        srst = 1'b0;
        test_reset();
        test_immediate();
        test_register();
        test_refused();
        test_midreset();
        complete_run();
    end

    initial begin
        repeat (400) @(posedge clk);
        fail_count++;
        complete_run();
    end
endmodule
